// File: shared/lcb_pkg.sv
package lcb_pkg;
	// ----------------------------------------
	// Bank pointer values
	// ----------------------------------------
	localparam logic [7:0] BANK_PRIMARY = 8'h00;
	localparam logic [7:0] BANK_SECONDARY = 8'hAA;
	localparam logic [7:0] BANK_INDIVIDUAL = 8'h01;
	localparam logic [7:0] BANK_BERT = 8'h02;
	localparam logic [4:0] OFF_BANK_POINTER = 5'h1F;
	// ----------------------------------------
	// Secondary bank offsets
	// ----------------------------------------
	localparam logic [4:0] OFF_RAIL_MODE = 5'h00;
	localparam logic [4:0] OFF_LINE_CODE = 5'h01;
	localparam logic [4:0] OFF_RX_POWER_DOWN = 5'h03;
	localparam logic [4:0] OFF_TX_POWER_DOWN = 5'h04;
	localparam logic [4:0] OFF_ZERO_RUN = 5'h05;
	localparam logic [4:0] OFF_CV_DISABLE = 5'h06;
	// ----------------------------------------
	// Individual bank offsets
	// ----------------------------------------
	localparam logic [4:0] OFF_ATTEN_ENABLE = 5'h00;
	localparam logic [4:0] OFF_ATTEN_POSITION = 5'h01;
	localparam logic [4:0] OFF_FIFO_DEPTH = 5'h02;
	localparam logic [4:0] OFF_FIFO_LIMIT = 5'h03;
	localparam logic [4:0] OFF_PROTECT_DISABLE = 5'h04;
	localparam logic [4:0] OFF_ALARM_ON_LOSS = 5'h05;
	localparam logic [4:0] OFF_MASTER_CLOCK = 5'h06;
	// ----------------------------------------
	// Primary bank globals (own offsets)
	// ----------------------------------------
	localparam logic [4:0] OFF_GLOBAL_CONFIG = 5'h0F;
	localparam logic [4:0] OFF_STATUS_CONTROL = 5'h1E;
	// Global config fields
	localparam int GC_ATTEN_ENABLE = 0;
	localparam int GC_ATTEN_POSITION = 1;
	localparam int GC_DEPTH = 3;
	localparam int GC_AMI = 4;
	localparam int GC_PROTECT = 5;
	localparam int GC_ALARM = 6;
	localparam int SC_CLEAR_ON_WRITE = 0;
	// Master clock fields
	localparam int MC_PLL_ENABLE = 0;
	localparam int MC_FREQ_FAMILY = 1;
	localparam int MC_PERIOD_LO = 2;
	localparam int MC_AUX_OUT_EN = 4;
	localparam int MC_LINE_OUT_EN = 5;
	localparam int MC_PLL_INPUT = 6;
	localparam logic [7:0] MC_WRITE_MASK = 8'h7F;
	localparam logic [7:0] SC_WRITE_MASK = 8'h03;
	localparam logic [7:0] GC_WRITE_MASK = 8'hFB;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// Jitter FIFO depths and trip margin
	localparam int FIFO_DEPTH_DEEP = 128;
	localparam int FIFO_DEPTH_SHALLOW = 32;
	localparam int FIFO_TRIP_MARGIN = 4;
endpackage

// File: src/lcb_config_bank.sv
// Summary of operation
// - Rail bit one single-rail, zero dual-rail
// - Line bit selects AMI; global AMI overrides
// - Receive power-down bit powers receiver down
// - Transmit power-down bit powers transmitter down
// - Zero detect enabled only single-rail, substitution
// - Code-violation disable bit; HDB3 only, AMI ignores
// - Attenuator enable bit; global enable overrides
// - Position bit: one receive, zero transmit
// - Depth bit 128 else 32, global override
// - Latch trip flag within four bits, attenuator enabled in transmit only
// - Trip flag clears on read or write-one
// - Protection disable bit; global disable overrides
// - AIS on loss per channel, global overrides
// - PLL input master clock or recovered clock
// - Line clock output else loss indication
// - Aux clock output drives or tristates
// - Period and family bits declare master rate
// - PLL enable; off uses master clock directly
// - Global clear-on-write mode for latched flags
`timescale 1ns/100ps
`default_nettype none
module lcb_config_bank
	import lcb_pkg::*;
#(
	parameter int CHANNELS = 8,
	parameter int FILL_WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [6:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Channel status from line side
	input wire logic [CHANNELS-1:0] rx_loss_i,
	input wire logic [CHANNELS*FILL_WIDTH-1:0] tx_fifo_fill_i,
	input wire logic [CHANNELS-1:0] line_rate_clock_i,
	input wire logic aux_clock_i,
	// Per-channel effective controls
	output logic [CHANNELS-1:0] single_rail_o,
	output logic [CHANNELS-1:0] ami_code_o,
	output logic [CHANNELS-1:0] rx_power_down_o,
	output logic [CHANNELS-1:0] tx_power_down_o,
	output logic [CHANNELS-1:0] zero_run_detect_o,
	output logic [CHANNELS-1:0] code_violation_detect_o,
	output logic [CHANNELS-1:0] atten_enable_o,
	output logic [CHANNELS-1:0] atten_in_rx_o,
	output logic [CHANNELS-1:0] fifo_deep_o,
	output logic [CHANNELS-1:0] short_protect_o,
	output logic [CHANNELS-1:0] send_alarm_o,
	// Master clock controls
	output logic pll_enable_o,
	output logic pll_from_recovered_o,
	output logic freq_family_t1_o,
	output logic [1:0] master_period_o,
	output logic line_rate_clock_out_o,
	output logic aux_clock_out_o,
	output logic aux_clock_out_oe_o
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] bank_pointer_reg;
	logic [7:0] global_config_reg;
	logic [7:0] status_control_reg;
	logic [7:0] rail_mode_bits_reg;
	logic [7:0] line_code_bits_reg;
	logic [7:0] rx_power_down_bits_reg;
	logic [7:0] tx_power_down_bits_reg;
	logic [7:0] zero_run_detect_bits_reg;
	logic [7:0] code_violation_disable_bits_reg;
	logic [7:0] atten_enable_reg;
	logic [7:0] atten_position_reg;
	logic [7:0] fifo_depth_reg;
	logic [7:0] fifo_limit_trip_flag_reg;
	logic [7:0] protect_disable_reg;
	logic [7:0] alarm_on_loss_reg;
	logic [7:0] master_clock_select_reg;
	logic [CHANNELS-1:0] loss_meta_reg;
	logic [CHANNELS-1:0] loss_sync_reg;
	logic [CHANNELS-1:0] trip_now;
	logic [7:0] read_next;
	logic [4:0] offset;
	logic in_secondary;
	logic in_individual;
	logic access;
	logic wr;
	logic rd_trip;
	logic wr_trip;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	// Word addressed; the low lane carries all data
	assign offset = adr_i[6:2];
	assign access = cyc_i && stb_i && !ack_o;
	assign wr = access && we_i && sel_i[0];
	// Host picks the bank first; low offsets alias per bank
	assign in_secondary = (bank_pointer_reg == BANK_SECONDARY);
	assign in_individual = (bank_pointer_reg == BANK_INDIVIDUAL);
	assign rd_trip = access && !we_i && in_individual && (offset == OFF_FIFO_LIMIT);
	assign wr_trip = wr && in_individual && (offset == OFF_FIFO_LIMIT);

	// Single-cycle acknowledge, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= access;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		read_next = 8'h00;
		if (offset == OFF_BANK_POINTER) begin
			read_next = bank_pointer_reg;
		end else if (offset == OFF_GLOBAL_CONFIG && !in_secondary && !in_individual) begin
			read_next = global_config_reg;
		end else if (offset == OFF_STATUS_CONTROL && !in_secondary && !in_individual) begin
			read_next = status_control_reg;
		end else if (in_secondary) begin
			case (offset)
				OFF_RAIL_MODE: read_next = rail_mode_bits_reg;
				OFF_LINE_CODE: read_next = line_code_bits_reg;
				OFF_RX_POWER_DOWN: read_next = rx_power_down_bits_reg;
				OFF_TX_POWER_DOWN: read_next = tx_power_down_bits_reg;
				OFF_ZERO_RUN: read_next = zero_run_detect_bits_reg;
				OFF_CV_DISABLE: read_next = code_violation_disable_bits_reg;
				default: read_next = 8'h00;
			endcase
		end else if (in_individual) begin
			case (offset)
				OFF_ATTEN_ENABLE: read_next = atten_enable_reg;
				OFF_ATTEN_POSITION: read_next = atten_position_reg;
				OFF_FIFO_DEPTH: read_next = fifo_depth_reg;
				OFF_FIFO_LIMIT: read_next = fifo_limit_trip_flag_reg;
				OFF_PROTECT_DISABLE: read_next = protect_disable_reg;
				OFF_ALARM_ON_LOSS: read_next = alarm_on_loss_reg;
				OFF_MASTER_CLOCK: read_next = master_clock_select_reg;
				default: read_next = 8'h00;
			endcase
		end
	end

	// Read data registered with the acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (access && !we_i) begin
			dat_o <= {24'h000000, read_next};
		end
	end

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	// Pointer register visible in every bank; global registers only outside the secondary and individual banks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bank_pointer_reg <= RESET_VALUE;
			global_config_reg <= RESET_VALUE;
			status_control_reg <= RESET_VALUE;
		end else if (wr) begin
			if (offset == OFF_BANK_POINTER) begin
				bank_pointer_reg <= dat_i[7:0];
			end
			if (offset == OFF_GLOBAL_CONFIG && !in_secondary && !in_individual) begin
				global_config_reg <= dat_i[7:0] & GC_WRITE_MASK;
			end
			if (offset == OFF_STATUS_CONTROL && !in_secondary && !in_individual) begin
				status_control_reg <= dat_i[7:0] & SC_WRITE_MASK;
			end
		end
	end

	// Secondary bank
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rail_mode_bits_reg <= RESET_VALUE;
			line_code_bits_reg <= RESET_VALUE;
			rx_power_down_bits_reg <= RESET_VALUE;
			tx_power_down_bits_reg <= RESET_VALUE;
			zero_run_detect_bits_reg <= RESET_VALUE;
			code_violation_disable_bits_reg <= RESET_VALUE;
		end else if (wr && in_secondary) begin
			case (offset)
				OFF_RAIL_MODE: rail_mode_bits_reg <= dat_i[7:0];
				OFF_LINE_CODE: line_code_bits_reg <= dat_i[7:0];
				OFF_RX_POWER_DOWN: rx_power_down_bits_reg <= dat_i[7:0];
				OFF_TX_POWER_DOWN: tx_power_down_bits_reg <= dat_i[7:0];
				OFF_ZERO_RUN: zero_run_detect_bits_reg <= dat_i[7:0];
				OFF_CV_DISABLE: code_violation_disable_bits_reg <= dat_i[7:0];
				default: ;
			endcase
		end
	end

	// Individual bank
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			atten_enable_reg <= RESET_VALUE;
			atten_position_reg <= RESET_VALUE;
			fifo_depth_reg <= RESET_VALUE;
			protect_disable_reg <= RESET_VALUE;
			alarm_on_loss_reg <= RESET_VALUE;
			master_clock_select_reg <= RESET_VALUE;
		end else if (wr && in_individual) begin
			case (offset)
				OFF_ATTEN_ENABLE: atten_enable_reg <= dat_i[7:0];
				OFF_ATTEN_POSITION: atten_position_reg <= dat_i[7:0];
				OFF_FIFO_DEPTH: fifo_depth_reg <= dat_i[7:0];
				OFF_PROTECT_DISABLE: protect_disable_reg <= dat_i[7:0];
				OFF_ALARM_ON_LOSS: alarm_on_loss_reg <= dat_i[7:0];
				OFF_MASTER_CLOCK: master_clock_select_reg <= dat_i[7:0] & MC_WRITE_MASK;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Loss-of-signal synchroniser
	// ----------------------------------------
	// Loss comes from the line side, another timing domain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loss_meta_reg <= '0;
			loss_sync_reg <= '0;
		end else begin
			loss_meta_reg <= rx_loss_i;
			loss_sync_reg <= loss_meta_reg;
		end
	end

	// ----------------------------------------
	// Per-channel effective controls
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			logic ami;
			logic deep;
			logic [FILL_WIDTH-1:0] fill;
			logic [FILL_WIDTH:0] limit;
			// Bit ch steers channel ch+1
			assign ami = global_config_reg[GC_AMI] | line_code_bits_reg[ch];
			assign deep = global_config_reg[GC_DEPTH] | fifo_depth_reg[ch];
			assign fill = tx_fifo_fill_i[ch*FILL_WIDTH +: FILL_WIDTH];
			assign limit = deep ? (FILL_WIDTH+1)'(FIFO_DEPTH_DEEP - FIFO_TRIP_MARGIN)
				: (FILL_WIDTH+1)'(FIFO_DEPTH_SHALLOW - FIFO_TRIP_MARGIN);
			// Trip only matters with the attenuator in the transmit path
			assign trip_now[ch] = atten_enable_o[ch] && !atten_in_rx_o[ch]
				&& ({1'b0, fill} >= limit);
			assign single_rail_o[ch] = rail_mode_bits_reg[ch];
			assign ami_code_o[ch] = ami;
			assign rx_power_down_o[ch] = rx_power_down_bits_reg[ch];
			assign tx_power_down_o[ch] = tx_power_down_bits_reg[ch];
			assign zero_run_detect_o[ch] = zero_run_detect_bits_reg[ch]
				&& rail_mode_bits_reg[ch] && !ami;
			// HDB3 decoding only; AMI code ignores the disable bit
			assign code_violation_detect_o[ch] = !ami
				&& !code_violation_disable_bits_reg[ch];
			assign atten_enable_o[ch] = global_config_reg[GC_ATTEN_ENABLE]
				| atten_enable_reg[ch];
			assign atten_in_rx_o[ch] = global_config_reg[GC_ATTEN_POSITION]
				| atten_position_reg[ch];
			assign fifo_deep_o[ch] = deep;
			assign short_protect_o[ch] = !(global_config_reg[GC_PROTECT]
				| protect_disable_reg[ch]);
			assign send_alarm_o[ch] = loss_sync_reg[ch] && (global_config_reg[GC_ALARM]
				| alarm_on_loss_reg[ch]);
		end
	endgenerate

	// ----------------------------------------
	// FIFO limit trip flags
	// ----------------------------------------
	// A new trip wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_limit_trip_flag_reg <= RESET_VALUE;
		end else begin
			if (status_control_reg[SC_CLEAR_ON_WRITE]) begin
				if (wr_trip) begin
					fifo_limit_trip_flag_reg <= (fifo_limit_trip_flag_reg & ~dat_i[7:0])
						| 8'(trip_now);
				end else begin
					fifo_limit_trip_flag_reg <= fifo_limit_trip_flag_reg | 8'(trip_now);
				end
			end else if (rd_trip) begin
				fifo_limit_trip_flag_reg <= 8'(trip_now);
			end else begin
				fifo_limit_trip_flag_reg <= fifo_limit_trip_flag_reg | 8'(trip_now);
			end
		end
	end

	// ----------------------------------------
	// Master clock controls
	// ----------------------------------------
	assign pll_enable_o = master_clock_select_reg[MC_PLL_ENABLE];
	assign pll_from_recovered_o = master_clock_select_reg[MC_PLL_INPUT];
	// Family bit only counts when the PLL is on; off means plain T1 clock; period passes through always
	assign freq_family_t1_o = !master_clock_select_reg[MC_PLL_ENABLE]
		|| master_clock_select_reg[MC_FREQ_FAMILY];
	assign master_period_o = master_clock_select_reg[MC_PERIOD_LO +: 2];

	// Output pins registered to avoid glitching the mux
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_rate_clock_out_o <= 1'b0;
			aux_clock_out_o <= 1'b0;
			aux_clock_out_oe_o <= 1'b0;
		end else begin
			line_rate_clock_out_o <= master_clock_select_reg[MC_LINE_OUT_EN]
				? line_rate_clock_i[0] : |loss_sync_reg;
			aux_clock_out_o <= aux_clock_i;
			aux_clock_out_oe_o <= master_clock_select_reg[MC_AUX_OUT_EN];
		end
	end

endmodule // lcb_config_bank
`default_nettype wire

// File: test/lcb_props.sv
`timescale 1ns/100ps
`default_nettype none
module lcb_props #(
	parameter int CHANNELS = 8
) (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Line side and controls
	input wire logic [CHANNELS-1:0] rx_loss_i,
	input wire logic aux_clock_i,
	input wire logic [CHANNELS-1:0] single_rail_o,
	input wire logic [CHANNELS-1:0] ami_code_o,
	input wire logic [CHANNELS-1:0] zero_run_detect_o,
	input wire logic [CHANNELS-1:0] send_alarm_o,
	input wire logic pll_enable_o,
	input wire logic freq_family_t1_o,
	input wire logic aux_clock_out_o,
	input wire logic aux_clock_out_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ------
	// Bus handshake
	// ------
	a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack one cycle after request");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	// Read data only moves with an ack, upper bytes always zero
	a_data_hold: assert property (!ack_o |-> $stable(dat_o))
		else $error("read data moved without ack");
	a_upper_zero: assert property (dat_o[31:8] == 24'h0)
		else $error("read data upper bytes not zero");
	// ------
	// Channel and clock controls
	// ------
	a_pll_family: assert property (!pll_enable_o |-> freq_family_t1_o)
		else $error("PLL off without T1 family");
	a_alarm_loss: assert property ((send_alarm_o & ~$past(rx_loss_i, 2)) == '0)
		else $error("alarm without synchronised loss");
	a_zero_gate: assert property ((zero_run_detect_o & (~single_rail_o | ami_code_o)) == '0)
		else $error("zero detect outside single rail substitution");
	a_aux_follow: assert property (aux_clock_out_oe_o |-> aux_clock_out_o == $past(aux_clock_i))
		else $error("aux clock output not following source");
	// Main scenarios reached
	c_alarm: cover property (send_alarm_o != '0);
	c_zero: cover property (zero_run_detect_o != '0);
	c_aux: cover property (aux_clock_out_oe_o);
endmodule // lcb_props
`default_nettype wire

// File: test/lcb_line_model.sv
`timescale 1ns/100ps
`default_nettype none
module lcb_line_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Requested line state
	input wire logic [7:0] loss_req_i,
	input wire logic [63:0] fill_req_i,
	// Line-side outputs
	output logic [7:0] rx_loss_o,
	output logic [63:0] fill_o,
	output logic [7:0] rclk_o,
	output logic aclk_o
);
	// State moves one edge after the request, like a real channel
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_loss_o <= 8'h00;
			fill_o <= 64'h0;
		end else begin
			rx_loss_o <= loss_req_i;
			fill_o <= fill_req_i;
		end
	end
	// Recovered clocks free-run so a stuck copy shows up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rclk_o <= 8'h55;
			aclk_o <= 1'b0;
		end else begin
			rclk_o <= ~rclk_o;
			aclk_o <= ~aclk_o;
		end
	end
endmodule // lcb_line_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
	import lcb_pkg::*;
	// ------
	// Signals
	// ------
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, aclk, phase_loop_enable, pllr, fam, lro, axo, axoe;
	logic [6:0] adr = 0;
	logic [3:0] sel = 0;
	logic [31:0] wdat = 0, rdat;
	logic [7:0] loss_req = 0, rx_loss, rclk, rail, amic, rxpd, txpd, zrun, cvd, aen, arx, deep;
	logic [7:0] scp, alarm;
	logic [63:0] fill_req = 0, fill;
	logic [1:0] per;
	int fails = 0, checked = 0, cycles = 0;
	// Clock and hang guard
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end
	lcb_line_model line_u (.clk_i(clk), .rst_i(rst), .loss_req_i(loss_req), .fill_req_i(fill_req),
		.rx_loss_o(rx_loss), .fill_o(fill), .rclk_o(rclk), .aclk_o(aclk));
	lcb_config_bank #(.CHANNELS(8), .FILL_WIDTH(8)) dut_u (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.rx_loss_i(rx_loss), .tx_fifo_fill_i(fill), .line_rate_clock_i(rclk), .aux_clock_i(aclk),
		.single_rail_o(rail), .ami_code_o(amic), .rx_power_down_o(rxpd), .tx_power_down_o(txpd),
		.zero_run_detect_o(zrun), .code_violation_detect_o(cvd), .atten_enable_o(aen),
		.atten_in_rx_o(arx), .fifo_deep_o(deep), .short_protect_o(scp), .send_alarm_o(alarm),
		.pll_enable_o(phase_loop_enable), .pll_from_recovered_o(pllr), .freq_family_t1_o(fam),
		.master_period_o(per), .line_rate_clock_out_o(lro), .aux_clock_out_o(axo),
		.aux_clock_out_oe_o(axoe));
	// ------
	// Bus tasks: request held until the ack edge
	// ------
	task automatic bus(input logic w, input logic [4:0] o, input logic [7:0] d, input logic s,
		output logic [7:0] q);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {o, 2'b00};
		sel <= {3'h7, s};
		wdat <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 0;
		stb <= 0;
		@(negedge clk);
	endtask
	task automatic wr(input logic [4:0] o, input logic [7:0] d);
		logic [7:0] q;
		bus(1, o, d, 1, q);
	endtask
	task automatic rdc(input string n, input logic [4:0] o, input logic [7:0] e);
		logic [7:0] q;
		bus(0, o, 8'h00, 1, q);
		`CHK(n, e, q)
	endtask
	task automatic pulse(input logic [63:0] f);
		@(posedge clk) fill_req <= f;
		@(posedge clk) fill_req <= 64'h0;
	endtask
	// ------
	// Scenarios
	// ------
	task automatic t_secondary();
		logic [7:0] q;
		logic [7:0] pat[6] = '{8'hF0, 8'h0C, 8'h81, 8'h42, 8'hFF, 8'h33};
		logic [4:0] off[6] = '{OFF_RAIL_MODE, OFF_LINE_CODE, OFF_RX_POWER_DOWN,
			OFF_TX_POWER_DOWN, OFF_ZERO_RUN, OFF_CV_DISABLE};
		`CHK("protect", 8'hFF, scp)
		`CHK("family", 1'b1, fam)
		wr(OFF_BANK_POINTER, BANK_SECONDARY);
		foreach (pat[i]) wr(off[i], pat[i]);
		foreach (pat[i]) rdc("sec", off[i], pat[i]);
		bus(1, OFF_RAIL_MODE, 8'h00, 0, q);
		rdc("hole", 5'h02, 8'h00);
		`CHK("rail", 8'hF0, rail)
		`CHK("ami", 8'h0C, amic)
		`CHK("rxpd", 8'h81, rxpd)
		`CHK("txpd", 8'h42, txpd)
		`CHK("zrun", 8'hF0, zrun)
		`CHK("cv", 8'hC0, cvd)
		wr(OFF_BANK_POINTER, BANK_PRIMARY);
		wr(OFF_GLOBAL_CONFIG, 8'h10);
		`CHK("amig", 8'hFF, amic)
		`CHK("cvg", 8'h00, cvd)
		wr(OFF_GLOBAL_CONFIG, 8'h00);
	endtask
	task automatic t_individual();
		wr(OFF_BANK_POINTER, BANK_INDIVIDUAL);
		rdc("mc0", OFF_MASTER_CLOCK, RESET_VALUE);
		wr(OFF_ATTEN_ENABLE, 8'h0F);
		wr(OFF_ATTEN_POSITION, 8'h3C);
		wr(OFF_FIFO_DEPTH, 8'h55);
		wr(OFF_PROTECT_DISABLE, 8'h99);
		wr(OFF_ALARM_ON_LOSS, 8'h0F);
		@(posedge clk) loss_req <= 8'h5A;
		repeat (5) @(negedge clk);
		`CHK("aen", 8'h0F, aen)
		`CHK("arx", 8'h3C, arx)
		`CHK("deep", 8'h55, deep)
		`CHK("scp", 8'h66, scp)
		`CHK("alarm", 8'h0A, alarm)
		`CHK("lro", 1'b1, lro)
		wr(OFF_BANK_POINTER, BANK_PRIMARY);
		wr(OFF_GLOBAL_CONFIG, 8'h6B);
		`CHK("aeng", 8'hFF, aen)
		`CHK("deepg", 8'hFF, deep)
		`CHK("scpg", 8'h00, scp)
		`CHK("alarmg", 8'h5A, alarm)
		wr(OFF_GLOBAL_CONFIG, 8'h00);
		@(posedge clk) loss_req <= 8'h00;
	endtask
	task automatic t_trip();
		wr(OFF_BANK_POINTER, BANK_INDIVIDUAL);
		wr(OFF_ATTEN_ENABLE, 8'h03);
		wr(OFF_ATTEN_POSITION, 8'h00);
		wr(OFF_FIFO_DEPTH, 8'h02);
		pulse({48'h0, 8'h7B, 8'h1B});
		rdc("trip0", OFF_FIFO_LIMIT, 8'h00);
		pulse({48'h0, 8'h7C, 8'h1C});
		rdc("trip1", OFF_FIFO_LIMIT, 8'h03);
		rdc("trip2", OFF_FIFO_LIMIT, 8'h00);
		wr(OFF_BANK_POINTER, BANK_PRIMARY);
		wr(OFF_STATUS_CONTROL, 8'h01);
		wr(OFF_BANK_POINTER, BANK_INDIVIDUAL);
		pulse({56'h0, 8'h1C});
		rdc("trip3", OFF_FIFO_LIMIT, 8'h01);
		rdc("trip4", OFF_FIFO_LIMIT, 8'h01);
		wr(OFF_FIFO_LIMIT, 8'h01);
		rdc("trip5", OFF_FIFO_LIMIT, 8'h00);
	endtask
	task automatic t_master();
		wr(OFF_MASTER_CLOCK, 8'hFF);
		rdc("mc", OFF_MASTER_CLOCK, 8'h7F);
		`CHK("mcf", 5'h1F, {pllr, per, fam, phase_loop_enable})
		// Registered pins carry the source as sampled one edge earlier
		`CHK("lro1", ~rclk[0], lro)
		`CHK("axo1", ~aclk, axo)
		wr(OFF_MASTER_CLOCK, 8'h0D);
		repeat (2) @(negedge clk);
		`CHK("mcg", 5'h0D, {pllr, per, fam, phase_loop_enable})
		`CHK("axoe0", 1'b0, axoe)
		`CHK("lro0", 1'b0, lro)
		wr(OFF_MASTER_CLOCK, 8'h30);
		repeat (2) @(negedge clk);
		`CHK("fam1", 2'h2, {fam, phase_loop_enable})
		`CHK("axoe1", 1'b1, axoe)
	endtask
	// Verdict and end of run
	task automatic summarize();
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		t_secondary();
		t_individual();
		t_trip();
		t_master();
		summarize();
	end
endmodule // tb_top
bind lcb_config_bank lcb_props #(.CHANNELS(CHANNELS)) props_u (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .rx_loss_i(rx_loss_i),
	.aux_clock_i(aux_clock_i), .single_rail_o(single_rail_o), .ami_code_o(ami_code_o),
	.zero_run_detect_o(zero_run_detect_o), .send_alarm_o(send_alarm_o),
	.pll_enable_o(pll_enable_o), .freq_family_t1_o(freq_family_t1_o),
	.aux_clock_out_o(aux_clock_out_o), .aux_clock_out_oe_o(aux_clock_out_oe_o));
`default_nettype wire
